/* File: design/nmp_cfg.svh */
// Constants for the narrow memory port control block
`ifndef NMP_CFG_SVH
`define NMP_CFG_SVH
`define NMP_SEL_LSB        26
`define NMP_SEL_MSB        31
`define NMP_SEL_W          6
`define NMP_SPACES         4
`define NMP_IDLE_SEL       4'hF
`define NMP_IDLE_BE        2'h3
`define NMP_STRAP_EXT      2'h0
`define NMP_STRAP_DIV4     2'h1
`define NMP_STRAP_DIV6     2'h2
`define NMP_DIV4_HALF      3'h2
`define NMP_DIV6_HALF      3'h3
`define NMP_RATIO_1        2'h0
`define NMP_RATIO_2        2'h1
`define NMP_RATIO_4        2'h2
`define NMP_WIDTH_16       1'h1
`define NMP_WIDTH_8        1'h0
`define NMP_STRAP_SETTLE   3'h4
`define NMP_SIZE_BYTE      2'h0
`define NMP_LANE_BOTH      2'h0
`define NMP_LANE_HI        2'h1
`define NMP_LANE_LO        2'h2
`endif

/* File: design/nmp_pkg.sv */
// Types shared by the narrow memory port control block
package nmp_pkg;
    // Access request from the core side
    typedef struct packed {
        logic        valid;
        logic [31:0] wordAddr;
        logic [1:0]  byteAddr;
        logic [1:0]  size;       // 0 byte, 1 halfword
        logic        directXfer;
    } nmp_req_t;

    // Pin-facing control outputs
    typedef struct packed {
        logic [3:0] spaceSelect_n;
        logic [1:0] byteLane_n;
        logic       directXfer_n;
    } nmp_pins_t;

    typedef enum logic [1:0] {NMP_OWN, NMP_DRAIN, NMP_HELD} nmp_arb_t;
endpackage

/* File: design/nmp_clock_gen.sv */
// Port clock source selection and output clock generation
`timescale 1ns/1ps
`include "nmp_cfg.svh"
module nmp_clock_gen (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       reset_n,
    input  wire logic       clkEn,
    // Clock inputs
    input  wire logic       extClkLevel,
    input  wire logic [1:0] clockSource,
    input  wire logic [1:0] outRatio,
    // Generated clocks
    output logic            portClockOutFull,
    output logic            portClockOutDivided
);
    // ***************************
    // Source and divider state
    // ***************************
    logic [2:0] divCnt_q, divCnt_d;
    logic       inClk_q, inClk_d;
    logic       prevIn_q, prevIn_d;
    logic [1:0] outCnt_q, outCnt_d;
    logic       full_q, full_d;
    logic       div_q, div_d;
    logic [2:0] half;
    logic       srcLevel;

    // Pick the input clock; internal dividers toggle every half period
    always_comb begin
        half = (clockSource == `NMP_STRAP_DIV6) ? `NMP_DIV6_HALF : `NMP_DIV4_HALF;
        divCnt_d = divCnt_q + 3'h1;
        inClk_d  = inClk_q;
        if (divCnt_q == half - 3'h1) begin
            divCnt_d = 3'h0;
            inClk_d  = ~inClk_q;
        end
        srcLevel = (clockSource == `NMP_STRAP_DIV4 || clockSource == `NMP_STRAP_DIV6) ? inClk_q
                                                                                     : extClkLevel;
        prevIn_d = srcLevel;
        full_d   = srcLevel;
        outCnt_d = outCnt_q;
        div_d    = div_q;
        // Divided clock advances on each rising edge of the source
        if (srcLevel && !prevIn_q) begin
            outCnt_d = outCnt_q + 2'h1;
            case (outRatio)
                `NMP_RATIO_2: div_d = ~div_q;
                `NMP_RATIO_4: div_d = outCnt_q[0] ? ~div_q : div_q;
                default:      div_d = div_q;
            endcase
        end
        if (outRatio == `NMP_RATIO_1) begin
            div_d = srcLevel;
        end
    end

    // Registers only
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            divCnt_q <= 3'h0;
            inClk_q  <= 1'h0;
            prevIn_q <= 1'h0;
            outCnt_q <= 2'h0;
            full_q   <= 1'h0;
            div_q    <= 1'h0;
        end else if (clkEn) begin
            divCnt_q <= divCnt_d;
            inClk_q  <= inClk_d;
            prevIn_q <= prevIn_d;
            outCnt_q <= outCnt_d;
            full_q   <= full_d;
            div_q    <= div_d;
        end
    end

    assign portClockOutFull    = full_q;
    assign portClockOutDivided = div_q;
endmodule

/* File: design/nmp_port_control.sv */
// Narrow memory port pin control: selects, byte lanes, hold arbitration, clocks
//
// Operation
// - Space select chosen from word address bits 26 and 27.
// - Exactly one space select active per external data access.
// - Byte lanes decoded from low address bits per configured width.
// - Byte lanes serve as write enables or SDRAM data mask.
// - Peripheral direct transfer output for peripheral-to-peripheral moves.
// - Hold acknowledge is driven once the host request is granted.
// - Bus request output shows a pending access while the host holds.
// - Port input clock source chosen at reset from two straps.
// - Default strap selection uses the external clock input.
// - Divided output clock is the input clock over 1, 2 or 4.
// - Full output clock runs at the input clock rate.
`timescale 1ns/1ps
`include "nmp_cfg.svh"
module nmp_port_control (
    // Clock, reset, enable
    input  wire logic             clk_sys,
    input  wire logic             reset_n,
    input  wire logic             clkEn,
    // Core access request
    input  wire nmp_pkg::nmp_req_t accessReq,
    input  wire logic             accessDone,
    input  wire logic             memWidth16,
    input  wire logic [1:0]       clockOutRatio,
    // Narrow memory port pins
    output nmp_pkg::nmp_pins_t    pinOut,
    output logic                  pinOutEnable_n,
    output logic                  port_bus_request,
    output logic                  host_hold_acknowledge,
    output logic                  portBusy,
    // Pin inputs from outside
    input  wire logic             host_hold_request,
    input  wire logic             port_external_clock_in,
    input  wire logic [1:0]       clock_source_strap_pins,
    // Generated clocks
    output logic                  port_clock_out_full,
    output logic                  port_clock_out_divided
);
    import nmp_pkg::*;

    // ***************************
    // Pin input synchronisers
    // ***************************
    logic [2:0] holdSync_q, holdSync_d;
    logic [2:0] clkSync_q, clkSync_d;
    logic [2:0] strapSync0_q, strapSync0_d;
    logic [2:0] strapSync1_q, strapSync1_d;
    logic       holdReq_q, holdReq_d;
    logic       extClk_q, extClk_d;

    // Three stages; a change counts once stages two and three agree
    always_comb begin
        holdSync_d   = {holdSync_q[1:0], host_hold_request};
        clkSync_d    = {clkSync_q[1:0], port_external_clock_in};
        strapSync0_d = {strapSync0_q[1:0], clock_source_strap_pins[0]};
        strapSync1_d = {strapSync1_q[1:0], clock_source_strap_pins[1]};
        holdReq_d    = (holdSync_q[1] == holdSync_q[2]) ? holdSync_q[2] : holdReq_q;
        extClk_d     = (clkSync_q[1] == clkSync_q[2]) ? clkSync_q[2] : extClk_q;
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            holdSync_q   <= 3'h0;
            clkSync_q    <= 3'h0;
            strapSync0_q <= 3'h0;
            strapSync1_q <= 3'h0;
            holdReq_q    <= 1'h0;
            extClk_q     <= 1'h0;
        end else if (clkEn) begin
            holdSync_q   <= holdSync_d;
            clkSync_q    <= clkSync_d;
            strapSync0_q <= strapSync0_d;
            strapSync1_q <= strapSync1_d;
            holdReq_q    <= holdReq_d;
            extClk_q     <= extClk_d;
        end
    end

    // ***************************
    // Strap capture
    // ***************************
    // Straps are sampled in the first cycles after reset release, so the latched value is the
    // level present at release; later pin use as address does not disturb it.
    logic [1:0] clkSrc_q, clkSrc_d;
    logic       resetSeen_q, resetSeen_d;
    logic [2:0] strapSettle_q, strapSettle_d;

    // Synced straps are taken only until the settle count runs out
    always_comb begin
        clkSrc_d = clkSrc_q;
        if (!resetSeen_q && strapSync0_q[1] == strapSync0_q[2] && strapSync1_q[1] == strapSync1_q[2]) begin
            clkSrc_d = {strapSync1_q[2], strapSync0_q[2]};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            clkSrc_q <= `NMP_STRAP_EXT;
        end else if (clkEn) begin
            clkSrc_q <= clkSrc_d;
        end
    end

    // Freeze the straps a few cycles after release, once the pipe is full
    always_comb begin
        strapSettle_d = strapSettle_q;
        resetSeen_d   = resetSeen_q;
        if (strapSettle_q != `NMP_STRAP_SETTLE) begin
            strapSettle_d = strapSettle_q + 3'h1;
        end else begin
            resetSeen_d = 1'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            strapSettle_q <= 3'h0;
            resetSeen_q   <= 1'h0;
        end else if (clkEn) begin
            strapSettle_q <= strapSettle_d;
            resetSeen_q   <= resetSeen_d;
        end
    end

    // ***************************
    // Bus arbitration
    // ***************************
    nmp_arb_t arb_q, arb_d;
    logic     active_q, active_d;
    logic     holdAck_q, holdAck_d;
    logic     busReq_q, busReq_d;

    // Host wins only between accesses; a started access always completes
    always_comb begin
        arb_d     = arb_q;
        active_d  = active_q;
        holdAck_d = 1'h0;
        busReq_d  = 1'h0;
        if (accessReq.valid && !active_q && arb_q == NMP_OWN && !holdReq_q) begin
            active_d = 1'h1;
        end else if (active_q && accessDone) begin
            active_d = 1'h0;
        end
        case (arb_q)
            NMP_OWN: begin
                if (holdReq_q) begin
                    arb_d = NMP_DRAIN;
                end
            end
            NMP_DRAIN: begin
                if (!active_q || accessDone) begin
                    arb_d = NMP_HELD;
                end
            end
            NMP_HELD: begin
                holdAck_d = 1'h1;
                busReq_d  = accessReq.valid;
                if (!holdReq_q) begin
                    arb_d     = NMP_OWN;
                    holdAck_d = 1'h0;
                end
            end
            default: arb_d = NMP_OWN;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            arb_q     <= NMP_OWN;
            active_q  <= 1'h0;
            holdAck_q <= 1'h0;
            busReq_q  <= 1'h0;
        end else if (clkEn) begin
            arb_q     <= arb_d;
            active_q  <= active_d;
            holdAck_q <= holdAck_d;
            busReq_q  <= busReq_d;
        end
    end

    // ***************************
    // Select and byte-lane decode
    // ***************************
    nmp_pins_t pins_q, pins_d;
    logic      oe_n_q, oe_n_d;
    logic [`NMP_SEL_W-1:0] spaceField;

    // Selects held for the whole access, released when idle
    always_comb begin
        spaceField = accessReq.wordAddr[`NMP_SEL_MSB:`NMP_SEL_LSB];
        pins_d = pins_q;
        oe_n_d = (arb_d == NMP_HELD);
        if (accessReq.valid && !active_q && arb_q == NMP_OWN && !holdReq_q) begin
            pins_d.spaceSelect_n = `NMP_IDLE_SEL;
            pins_d.spaceSelect_n[spaceField[1:0]] = 1'h0;
            if (memWidth16 == `NMP_WIDTH_16) begin
                // Halfword uses both lanes; byte picks a lane by address bit 0
                pins_d.byteLane_n = (accessReq.size != `NMP_SIZE_BYTE) ? `NMP_LANE_BOTH
                                  : (accessReq.byteAddr[0] ? `NMP_LANE_HI : `NMP_LANE_LO);
            end else begin
                pins_d.byteLane_n = `NMP_LANE_LO;
            end
            pins_d.directXfer_n = ~accessReq.directXfer;
        end else if (!active_d) begin
            pins_d.spaceSelect_n = `NMP_IDLE_SEL;
            pins_d.byteLane_n    = `NMP_IDLE_BE;
            pins_d.directXfer_n  = 1'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            pins_q <= '{spaceSelect_n: `NMP_IDLE_SEL, byteLane_n: `NMP_IDLE_BE, directXfer_n: 1'h1};
            oe_n_q <= 1'h0;
        end else if (clkEn) begin
            pins_q <= pins_d;
            oe_n_q <= oe_n_d;
        end
    end

    // ***************************
    // Clock generation
    // ***************************
    nmp_clock_gen uClock (
        .clk_sys             (clk_sys),
        .reset_n             (reset_n),
        .clkEn               (clkEn),
        .extClkLevel         (extClk_q),
        .clockSource         (clkSrc_q),
        .outRatio            (clockOutRatio),
        .portClockOutFull    (port_clock_out_full),
        .portClockOutDivided (port_clock_out_divided)
    );

    assign pinOut                = pins_q;
    assign pinOutEnable_n        = oe_n_q;
    assign host_hold_acknowledge = holdAck_q;
    assign port_bus_request      = busReq_q;
    assign portBusy              = active_q;
endmodule

/* File: tb/nmp_port_control_assertions.sv */
// Checker for the narrow memory port pin control
`timescale 1ns/1ps
module nmp_port_control_checker (
    // Clock and reset
    input wire logic               clk_sys,
    input wire logic               reset_n,
    // Watched ports
    input wire nmp_pkg::nmp_req_t  accessReq,
    input wire logic               memWidth16,
    input wire nmp_pkg::nmp_pins_t pinOut,
    input wire logic               pinOutEnable_n,
    input wire logic               port_bus_request,
    input wire logic               host_hold_acknowledge,
    input wire logic               portBusy,
    input wire logic               host_hold_request
);
    import nmp_pkg::*;
    // One clock domain, so one default clocking and disable
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);
    // Access start: select, lanes and direct strobe tied to the request taken
    property p_sel;
        $rose(portBusy) |-> pinOut.spaceSelect_n == ~(4'h1 << $past(accessReq.wordAddr[27:26]));
    endproperty
    a_sel: assert property (p_sel) else $error("select does not match address");
    property p_one;
        portBusy |-> $onehot(~pinOut.spaceSelect_n);
    endproperty
    a_one: assert property (p_one) else $error("not exactly one select active");
    property p_lane;
        $rose(portBusy) |-> pinOut.byteLane_n == (!memWidth16 ? 2'h2 : $past(accessReq.size) != 2'h0 ? 2'h0 :
            $past(accessReq.byteAddr[0]) ? 2'h1 : 2'h2);
    endproperty
    a_lane: assert property (p_lane) else $error("byte lanes wrong");
    property p_dx;
        $rose(portBusy) |-> pinOut.directXfer_n == !$past(accessReq.directXfer);
    endproperty
    a_dx: assert property (p_dx) else $error("direct transfer strobe wrong");
    // Hold handshake: grant only with the port idle and floated
    property p_float;
        $rose(host_hold_acknowledge) |-> pinOutEnable_n && !portBusy;
    endproperty
    a_float: assert property (p_float) else $error("hold granted while driving");
    property p_grant;
        $rose(host_hold_request) && !portBusy && !accessReq.valid |-> ##[3:10] host_hold_acknowledge;
    endproperty
    a_grant: assert property (p_grant) else $error("hold not granted in time");
    property p_free;
        $fell(host_hold_request) |-> ##[2:8] !host_hold_acknowledge;
    endproperty
    a_free: assert property (p_free) else $error("hold grant not withdrawn");
    property p_breq;
        port_bus_request |-> !portBusy;
    endproperty
    a_breq: assert property (p_breq) else $error("bus request during own access");
endmodule

bind nmp_port_control nmp_port_control_checker i_nmp_port_control_checker (
    .clk_sys(clk_sys), .reset_n(reset_n), .accessReq(accessReq), .memWidth16(memWidth16),
    .pinOut(pinOut), .pinOutEnable_n(pinOutEnable_n), .port_bus_request(port_bus_request),
    .host_hold_acknowledge(host_hold_acknowledge), .portBusy(portBusy), .host_hold_request(host_hold_request));

/* File: tb/nmp_host_model.sv */
// Host and oscillator at the far side of the narrow memory port
`timescale 1ns/1ps
module nmp_host_model (
    // Clock and control from the bench
    input  wire logic clk_sys,
    input  wire logic wantBus,
    // Port pins
    input  wire logic host_hold_acknowledge,
    output logic      host_hold_request,
    output logic      port_external_clock_in
);
    logic reqQ = 1'b0;
    assign host_hold_request = reqQ;
    // Free running oscillator, phase unrelated to the system clock
    initial begin
        port_external_clock_in = 1'b0;
        #3;
        forever #20 port_external_clock_in = ~port_external_clock_in;
    end
    // Request kept until granted, so a grant in flight is never abandoned;
    // it moves just after the rising edge so the falling-edge bench never races it
    always @(posedge clk_sys) begin
        if (wantBus)
            reqQ <= 1'b1;
        else if (host_hold_acknowledge)
            reqQ <= 1'b0;
    end
endmodule

/* File: tb/tb.sv */
// Testbench for the narrow memory port pin control
`timescale 1ns/1ps
module tb;
    import nmp_pkg::*;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic clkEn = 1'b1;
    nmp_req_t accessReq = '0;
    logic accessDone = 1'b0;
    logic memWidth16 = 1'b1;
    logic [1:0] clockOutRatio = 2'h0;
    logic [1:0] straps = 2'h0;
    logic wantBus = 1'b0;
    nmp_pins_t pinOut;
    logic oeN, busReq, holdAck, portBusy, holdReq, extClk, clkFull, clkDiv;
    int fail_count = 0;
    int checks = 0;
    // 200 MHz system clock
    always #2.5 clk_sys = ~clk_sys;
    nmp_port_control i_nmp_port_control (.clk_sys(clk_sys), .reset_n(reset_n), .clkEn(clkEn),
        .accessReq(accessReq), .accessDone(accessDone), .memWidth16(memWidth16), .clockOutRatio(clockOutRatio),
        .pinOut(pinOut), .pinOutEnable_n(oeN), .port_bus_request(busReq), .host_hold_acknowledge(holdAck),
        .portBusy(portBusy), .host_hold_request(holdReq), .port_external_clock_in(extClk),
        .clock_source_strap_pins(straps), .port_clock_out_full(clkFull), .port_clock_out_divided(clkDiv));
    nmp_host_model i_nmp_host_model (.clk_sys(clk_sys), .wantBus(wantBus), .host_hold_acknowledge(holdAck),
        .host_hold_request(holdReq), .port_external_clock_in(extClk));
    // Compare helpers
    task automatic check(string what, logic [7:0] exp, logic [7:0] got);
        checks++;
        if (exp !== got) begin
            fail_count++;
            $display("CHECK FAILED %s exp %h got %h", what, exp, got);
        end
    endtask
    // Counts carry a cycle of sampling jitter, hence the tolerance
    task automatic near(string what, int exp, int got);
        checks++;
        if (got < exp - 1 || got > exp + 1) begin
            fail_count++;
            $display("CHECK FAILED %s exp %0d got %0d", what, exp, got);
        end
    endtask
    task automatic final_report();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Bounded wait at falling edges
    task automatic wait_for(ref logic sig, input logic want);
        int n;
        n = 0;
        while (sig !== want) begin
            @(negedge clk_sys);
            n++;
            if (n > 20) begin
                fail_count++;
                $display("CHECK FAILED wait exp %b got %b", want, sig);
                final_report();
            end
        end
    endtask
    task automatic do_reset();
        reset_n = 1'b0;
        repeat (10) @(negedge clk_sys);
        reset_n = 1'b1;
    endtask
    // Access request held until taken, then select checked
    task automatic start_access(logic [1:0] k, logic ba, logic sz, logic dx);
        accessReq = '{1'b1, {4'hA, k, 26'h0000123}, {1'b0, ba}, {1'b0, sz}, dx};
        wait_for(portBusy, 1'b1);
        accessReq.valid = 1'b0;
        check("select", {4'h0, ~(4'h1 << k)}, {4'h0, pinOut.spaceSelect_n});
    endtask
    task automatic end_access();
        accessDone = 1'b1;
        @(negedge clk_sys);
        accessDone = 1'b0;
        wait_for(portBusy, 1'b0);
        check("idle select", 8'h0F, {4'h0, pinOut.spaceSelect_n});
    endtask
    // Back-to-back accesses over every select, lane case and width
    task automatic test_access();
        logic [1:0] lane;
        for (int i = 0; i < 8; i++) begin
            memWidth16 = (i < 6);
            lane = !memWidth16 ? 2'h2 : (i % 3 == 2) ? 2'h0 : i[0] ? 2'h1 : 2'h2;
            start_access(2'(i), i[0], i % 3 == 2, i[1]);
            check("lanes", {6'h0, lane}, {6'h0, pinOut.byteLane_n});
            check("direct", {7'h0, ~i[1]}, {7'h0, pinOut.directXfer_n});
            check("drive", 8'h00, {7'h0, oeN});
            end_access();
        end
        $display("test_access done");
    endtask
    task automatic hold_cycle();
        wantBus = 1'b1;
        wait_for(holdAck, 1'b1);
        check("float", 8'h01, {7'h0, oeN});
        check("bus request", {7'h0, accessReq.valid}, {7'h0, busReq});
        wantBus = 1'b0;
        wait_for(holdAck, 1'b0);
    endtask
    // Idle hold, then hold arriving mid-access with a request pending
    task automatic test_hold();
        hold_cycle();
        start_access(2'h1, 1'b0, 1'b1, 1'b0);
        wantBus = 1'b1;
        repeat (10) @(negedge clk_sys);
        check("grant while busy", 8'h00, {7'h0, holdAck});
        accessReq = '{1'b1, 32'h0800_0000, 2'h0, 2'h1, 1'b0};
        end_access();
        hold_cycle();
        wait_for(portBusy, 1'b1);
        accessReq.valid = 1'b0;
        check("select after hold", 8'h0B, {4'h0, pinOut.spaceSelect_n});
        end_access();
        $display("test_hold done");
    endtask
    // Enable low freezes state: an end pulse during the freeze is lost
    task automatic test_freeze();
        start_access(2'h3, 1'b0, 1'b1, 1'b0);
        clkEn = 1'b0;
        accessDone = 1'b1;
        repeat (3) @(negedge clk_sys);
        accessDone = 1'b0;
        clkEn = 1'b1;
        repeat (2) @(negedge clk_sys);
        check("frozen busy", 8'h01, {7'h0, portBusy});
        check("frozen select", 8'h07, {4'h0, pinOut.spaceSelect_n});
        end_access();
        $display("test_freeze done");
    endtask
    // Each strap code after its own reset, with a divide ratio each
    task automatic test_clocks();
        int nFull, nDiv, eFull;
        logic pf, pd;
        for (int s = 0; s < 4; s++) begin
            straps = 2'(s);
            clockOutRatio = 2'(s % 3);
            do_reset();
            repeat (20) @(negedge clk_sys);
            nFull = 0;
            nDiv = 0;
            pf = clkFull;
            pd = clkDiv;
            repeat (240) begin
                @(negedge clk_sys);
                nFull += int'(clkFull && !pf);
                nDiv += int'(clkDiv && !pd);
                pf = clkFull;
                pd = clkDiv;
            end
            eFull = (s == 1) ? 60 : (s == 2) ? 40 : 30;
            near("full clock", eFull, nFull);
            near("divided clock", eFull >> (s % 3), nDiv);
        end
        $display("test_clocks done");
    endtask
    initial begin
        do_reset();
        test_access();
        test_hold();
        test_freeze();
        test_clocks();
        final_report();
    end
endmodule
